// ===== rtl/mcsv_defs.vh
// Constants for the motor current scale and velocity mode block
`ifndef MCSV_DEFS_VH
`define MCSV_DEFS_VH
`define MCSV_CLK_HZ          50000000
`define MCSV_TICK_CLKS       262144
`define MCSV_STST_CLKS       1048576
`define MCSV_IVL_W           20
`define MCSV_IVL_MAX         20'hFFFFF
`define MCSV_ADDR_CUR        8'h00
`define MCSV_ADDR_PDOWN      8'h04
`define MCSV_ADDR_TRIM       8'h08
`define MCSV_ADDR_QUIET      8'h0C
`define MCSV_ADDR_HIGH       8'h10
`define MCSV_ADDR_LOAD       8'h14
`define MCSV_ADDR_CFG        8'h18
`define MCSV_ADDR_STAT       8'h1C
`define MCSV_ADDR_IVL        8'h20
`define MCSV_CUR_RUN_LSB     0
`define MCSV_CUR_HOLD_LSB    8
`define MCSV_CUR_DLY_LSB     16
`define MCSV_CFG_HYST_BIT    0
`define MCSV_CFG_SHIFT_LSB   4
`define MCSV_STAT_STST_BIT   0
`define MCSV_STAT_QUIET_BIT  1
`define MCSV_STAT_HIGH_BIT   2
`define MCSV_STAT_LOAD_BIT   3
`define MCSV_STAT_CS_LSB     8
`define MCSV_RST_RUN         5'h1F
`define MCSV_RST_HOLD        5'h10
`define MCSV_RST_DLY         4'h1
`define MCSV_RST_PDOWN       8'h0A
`define MCSV_RST_TRIM        8'h00
`define MCSV_RST_LIMIT       20'h00000
`define MCSV_RESP_OKAY       2'h0
`define MCSV_RESP_SLVERR     2'h2
`endif

// ===== rtl/mcsv_step_timer.v
// Step interval measurement and standstill detection
`timescale 1ns/1ps
`include "mcsv_defs.vh"
module mcsv_step_timer #(
  parameter integer STST_CLKS = `MCSV_STST_CLKS
) (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire        step_pulse,
  input  wire [3:0]  step_shift,
  output reg  [19:0] step_interval_r,
  output reg         standstill_r
);
  reg  [20:0] cnt_r;
  wire [20:0] elapsed = cnt_r + 21'h000001;
  wire [20:0] norm    = elapsed >> step_shift;

  always @(posedge aclk) begin
    if (!aresetn) begin
      cnt_r           <= 21'h100000;
      step_interval_r <= `MCSV_IVL_MAX;
      standstill_r    <= 1'b1;
    end else if (step_pulse) begin
      cnt_r        <= 21'h000000;
      standstill_r <= 1'b0;
      if (norm[20] || standstill_r)
        step_interval_r <= `MCSV_IVL_MAX;
      else
        step_interval_r <= norm[19:0];
    end else if (elapsed >= STST_CLKS[20:0]) begin
      standstill_r    <= 1'b1;
      step_interval_r <= `MCSV_IVL_MAX;
    end else begin
      cnt_r <= elapsed;
    end
  end
endmodule

// ===== rtl/mcsv_thresh_cmp.v
// One interval threshold comparison with hysteresis
`timescale 1ns/1ps
module mcsv_thresh_cmp (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire [19:0] step_interval,
  input  wire [19:0] interval_limit,
  input  wire        small_hyst,
  output reg         fast_r
);
  wire [20:0] hyst_add = small_hyst ? {6'h00, step_interval[19:5]} : {5'h00, step_interval[19:4]};
  wire [20:0] ivl_hyst = {1'b0, step_interval} + hyst_add;

  always @(posedge aclk) begin
    if (!aresetn)
      fast_r <= 1'b0;
    else if (ivl_hyst <= {1'b0, interval_limit})
      fast_r <= 1'b1;
    else if (step_interval > interval_limit)
      fast_r <= 1'b0;
  end
endmodule

// ===== rtl/mcsv_top.v
// Coil current scaling, hold ramp and velocity mode selection with AXI4-Lite registers
//
// Added by the designer: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ps
`include "mcsv_defs.vh"
module mcsv_top #(
  parameter integer TICK_CLKS = `MCSV_TICK_CLKS,
  parameter integer STST_CLKS = `MCSV_STST_CLKS
) (
  input  wire               aclk,
  input  wire               aresetn,
  input  wire [7:0]         s_axi_awaddr,
  input  wire               s_axi_awvalid,
  output reg                s_axi_awready,
  input  wire [31:0]        s_axi_wdata,
  input  wire [3:0]         s_axi_wstrb,
  input  wire               s_axi_wvalid,
  output reg                s_axi_wready,
  output reg  [1:0]         s_axi_bresp,
  output reg                s_axi_bvalid,
  input  wire               s_axi_bready,
  input  wire [7:0]         s_axi_araddr,
  input  wire               s_axi_arvalid,
  output reg                s_axi_arready,
  output reg  [31:0]        s_axi_rdata,
  output reg  [1:0]         s_axi_rresp,
  output reg                s_axi_rvalid,
  input  wire               s_axi_rready,
  input  wire               step_pulse,
  input  wire signed [8:0]  sine_a_in,
  input  wire signed [8:0]  sine_b_in,
  input  wire [4:0]         load_adapt_scale_req,
  output reg  signed [8:0]  coil_a_out,
  output reg  signed [8:0]  coil_b_out,
  output reg  [4:0]         current_scale,
  output wire               standstill,
  output reg                quiet_mode_active,
  output reg                high_speed_active,
  output reg                load_adapt_active
);
  localparam [3:0] ST_RUN  = 4'b0001;
  localparam [3:0] ST_WAIT = 4'b0010;
  localparam [3:0] ST_RAMP = 4'b0100;
  localparam [3:0] ST_HOLD = 4'b1000;

  // Configuration registers
  reg  [4:0]  run_current_scale_r;
  reg  [4:0]  hold_current_scale_r;
  reg  [3:0]  hold_ramp_delay_r;
  reg  [7:0]  power_down_delay_r;
  reg  [7:0]  global_current_trim_r;
  reg  [19:0] quiet_mode_interval_limit_r;
  reg  [19:0] high_speed_interval_limit_r;
  reg  [19:0] load_adapt_interval_limit_r;
  reg         small_hyst_r;
  reg  [3:0]  step_shift_r;

  // Bus state
  reg  [7:0]  aw_addr_r;
  reg         aw_held_r;
  reg  [31:0] w_data_r;
  reg  [3:0]  w_strb_r;
  reg         w_held_r;

  // Ramp state
  reg  [3:0]  state_r;
  reg  [3:0]  state_nxt;
  reg  [17:0] div_r;
  reg  [7:0]  unit_r;
  reg  [4:0]  cs_r;
  reg  [4:0]  cs_nxt;

  wire [19:0] step_interval;
  wire [2:0]  fast;
  wire [59:0] limits = {load_adapt_interval_limit_r, high_speed_interval_limit_r, quiet_mode_interval_limit_r};

  mcsv_step_timer #(
    .STST_CLKS       (STST_CLKS)
  ) u_timer (
    .aclk            (aclk),
    .aresetn         (aresetn),
    .step_pulse      (step_pulse),
    .step_shift      (step_shift_r),
    .step_interval_r (step_interval),
    .standstill_r    (standstill)
  );

  // One comparator per limit: quiet, high speed, load adapt
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_cmp
      mcsv_thresh_cmp u_cmp (
        .aclk           (aclk),
        .aresetn        (aresetn),
        .step_interval  (step_interval),
        .interval_limit (limits[gi*20 +: 20]),
        .small_hyst     (small_hyst_r),
        .fast_r         (fast[gi])
      );
    end
  endgenerate

  // Register read view
  function [31:0] rd_word;
    input [7:0] addr;
    begin
      rd_word = 32'h00000000;
      if (addr == `MCSV_ADDR_CUR) begin
        rd_word[`MCSV_CUR_RUN_LSB +: 5]  = run_current_scale_r;
        rd_word[`MCSV_CUR_HOLD_LSB +: 5] = hold_current_scale_r;
        rd_word[`MCSV_CUR_DLY_LSB +: 4]  = hold_ramp_delay_r;
      end else if (addr == `MCSV_ADDR_PDOWN) begin
        rd_word[7:0] = power_down_delay_r;
      end else if (addr == `MCSV_ADDR_TRIM) begin
        rd_word[7:0] = global_current_trim_r;
      end else if (addr == `MCSV_ADDR_QUIET) begin
        rd_word[19:0] = quiet_mode_interval_limit_r;
      end else if (addr == `MCSV_ADDR_HIGH) begin
        rd_word[19:0] = high_speed_interval_limit_r;
      end else if (addr == `MCSV_ADDR_LOAD) begin
        rd_word[19:0] = load_adapt_interval_limit_r;
      end else if (addr == `MCSV_ADDR_CFG) begin
        rd_word[`MCSV_CFG_HYST_BIT]      = small_hyst_r;
        rd_word[`MCSV_CFG_SHIFT_LSB +: 4] = step_shift_r;
      end else if (addr == `MCSV_ADDR_STAT) begin
        rd_word[`MCSV_STAT_STST_BIT]   = standstill;
        rd_word[`MCSV_STAT_QUIET_BIT]  = quiet_mode_active;
        rd_word[`MCSV_STAT_HIGH_BIT]   = high_speed_active;
        rd_word[`MCSV_STAT_LOAD_BIT]   = load_adapt_active;
        rd_word[`MCSV_STAT_CS_LSB +: 5] = current_scale;
      end else if (addr == `MCSV_ADDR_IVL) begin
        rd_word[19:0] = step_interval;
      end
    end
  endfunction

  function addr_ok;
    input [7:0] addr;
    begin
      addr_ok = (addr[1:0] == 2'h0) && (addr <= `MCSV_ADDR_IVL);
    end
  endfunction

  function addr_wr;
    input [7:0] addr;
    begin
      addr_wr = addr_ok(addr) && (addr != `MCSV_ADDR_STAT) && (addr != `MCSV_ADDR_IVL);
    end
  endfunction

  wire [31:0] wmask = {{8{w_strb_r[3]}}, {8{w_strb_r[2]}}, {8{w_strb_r[1]}}, {8{w_strb_r[0]}}};
  wire [31:0] wword = (rd_word(aw_addr_r) & ~wmask) | (w_data_r & wmask);
  wire        do_wr = aw_held_r && w_held_r && !s_axi_bvalid;

  // Write channel
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `MCSV_RESP_OKAY;
      aw_held_r     <= 1'b0;
      w_held_r      <= 1'b0;
      aw_addr_r     <= 8'h00;
      w_data_r      <= 32'h00000000;
      w_strb_r      <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_addr_r     <= s_axi_awaddr;
        aw_held_r     <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_data_r     <= s_axi_wdata;
        w_strb_r     <= s_axi_wstrb;
        w_held_r     <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (do_wr) begin
        aw_held_r    <= 1'b0;
        w_held_r     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= addr_wr(aw_addr_r) ? `MCSV_RESP_OKAY : `MCSV_RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // Register storage
  always @(posedge aclk) begin
    if (!aresetn) begin
      run_current_scale_r         <= `MCSV_RST_RUN;
      hold_current_scale_r        <= `MCSV_RST_HOLD;
      hold_ramp_delay_r           <= `MCSV_RST_DLY;
      power_down_delay_r          <= `MCSV_RST_PDOWN;
      global_current_trim_r       <= `MCSV_RST_TRIM;
      quiet_mode_interval_limit_r <= `MCSV_RST_LIMIT;
      high_speed_interval_limit_r <= `MCSV_RST_LIMIT;
      load_adapt_interval_limit_r <= `MCSV_RST_LIMIT;
      small_hyst_r                <= 1'b0;
      step_shift_r                <= 4'h0;
    end else if (do_wr) begin
      if (aw_addr_r == `MCSV_ADDR_CUR) begin
        run_current_scale_r  <= wword[`MCSV_CUR_RUN_LSB +: 5];
        hold_current_scale_r <= wword[`MCSV_CUR_HOLD_LSB +: 5];
        hold_ramp_delay_r    <= wword[`MCSV_CUR_DLY_LSB +: 4];
      end else if (aw_addr_r == `MCSV_ADDR_PDOWN) begin
        power_down_delay_r <= wword[7:0];
      end else if (aw_addr_r == `MCSV_ADDR_TRIM) begin
        global_current_trim_r <= wword[7:0];
      end else if (aw_addr_r == `MCSV_ADDR_QUIET) begin
        quiet_mode_interval_limit_r <= wword[19:0];
      end else if (aw_addr_r == `MCSV_ADDR_HIGH) begin
        high_speed_interval_limit_r <= wword[19:0];
      end else if (aw_addr_r == `MCSV_ADDR_LOAD) begin
        load_adapt_interval_limit_r <= wword[19:0];
      end else if (aw_addr_r == `MCSV_ADDR_CFG) begin
        small_hyst_r <= wword[`MCSV_CFG_HYST_BIT];
        step_shift_r <= (wword[`MCSV_CFG_SHIFT_LSB +: 4] > 4'h8) ? 4'h8 : wword[`MCSV_CFG_SHIFT_LSB +: 4];
      end
    end
  end

  // Read channel
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= `MCSV_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rd_word(s_axi_araddr);
      s_axi_rresp   <= addr_ok(s_axi_araddr) ? `MCSV_RESP_OKAY : `MCSV_RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // Velocity dependent modes follow the comparators; high speed masks load adapt
  always @(posedge aclk) begin
    if (!aresetn) begin
      quiet_mode_active <= 1'b1;
      high_speed_active <= 1'b0;
      load_adapt_active <= 1'b0;
    end else begin
      quiet_mode_active <= !fast[0];
      high_speed_active <= fast[1];
      load_adapt_active <= fast[2] && !fast[1];
    end
  end

  // Run level, capped by load_adapt_scale_req when load adapt acts
  wire [4:0] run_level = (load_adapt_active && load_adapt_scale_req < run_current_scale_r) ?
                         load_adapt_scale_req : run_current_scale_r;

  // Power-down timebase of 2^18 clocks, restarted per unit
  wire tick      = (div_r == TICK_CLKS[17:0] - 18'h00001);
  wire in_timing = state_r[1] | state_r[2];

  always @(posedge aclk) begin
    if (!aresetn)
      div_r <= 18'h00000;
    else if (!in_timing || tick || state_nxt != state_r)
      div_r <= 18'h00000;
    else
      div_r <= div_r + 18'h00001;
  end

  // Hold ramp sequencing
  always @* begin
    state_nxt = state_r;
    cs_nxt    = cs_r;
    case (state_r)
      ST_RUN: begin
        cs_nxt = run_level;
        if (standstill) begin
          state_nxt = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (unit_r == power_down_delay_r) begin
          state_nxt = ST_RAMP;
        end
      end
      ST_RAMP: begin
        if (hold_ramp_delay_r == 4'h0 || cs_r <= hold_current_scale_r) begin
          cs_nxt    = hold_current_scale_r;
          state_nxt = ST_HOLD;
        end else if (tick && unit_r == {4'h0, hold_ramp_delay_r - 4'h1}) begin
          cs_nxt = cs_r - 5'h01;
          if (cs_r - 5'h01 <= hold_current_scale_r) begin
            state_nxt = ST_HOLD;
          end
        end
      end
      ST_HOLD: begin
        cs_nxt = hold_current_scale_r;
      end
      default: begin
        state_nxt = ST_RUN;
      end
    endcase
    if (!standstill && state_r != ST_RUN) begin
      state_nxt = ST_RUN;
      cs_nxt    = run_level;
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      state_r <= ST_RUN;
      cs_r    <= `MCSV_RST_RUN;
      unit_r  <= 8'h00;
    end else begin
      state_r <= state_nxt;
      cs_r    <= cs_nxt;
      if (state_nxt != state_r)
        unit_r <= 8'h00;
      else if (state_r == ST_RAMP && tick && unit_r == {4'h0, hold_ramp_delay_r - 4'h1})
        unit_r <= 8'h00;
      else if (tick)
        unit_r <= unit_r + 8'h01;
    end
  end

  // Coil targets: sine * (cs+1)/32 * trim/256
  wire        [5:0]  cs_fac   = {1'b0, cs_r} + 6'h01;
  wire        [8:0]  trim_fac = (global_current_trim_r == 8'h00) ? 9'h100 : {1'b0, global_current_trim_r};
  wire signed [25:0] prod_a   = sine_a_in * $signed({1'b0, cs_fac}) * $signed({1'b0, trim_fac});
  wire signed [25:0] prod_b   = sine_b_in * $signed({1'b0, cs_fac}) * $signed({1'b0, trim_fac});

  always @(posedge aclk) begin
    if (!aresetn) begin
      coil_a_out    <= 9'h000;
      coil_b_out    <= 9'h000;
      current_scale <= `MCSV_RST_RUN;
    end else begin
      coil_a_out    <= prod_a[21:13];
      coil_b_out    <= prod_b[21:13];
      current_scale <= cs_r;
    end
  end
endmodule

// ===== tb/mcsv_checker.sv
// Assertion checker for the current scale and velocity mode block
`timescale 1ns/1ps
module mcsv_checker #(
  parameter integer STST_CLKS = 1048576
) (
  input wire       aclk,
  input wire       aresetn,
  input wire       s_axi_awvalid,
  input wire       s_axi_awready,
  input wire       s_axi_wvalid,
  input wire       s_axi_wready,
  input wire       s_axi_bvalid,
  input wire       s_axi_bready,
  input wire       s_axi_arvalid,
  input wire       s_axi_arready,
  input wire       s_axi_rvalid,
  input wire       s_axi_rready,
  input wire       step_pulse,
  input wire [4:0] current_scale,
  input wire       standstill,
  input wire       high_speed_active,
  input wire       load_adapt_active
);
  reg [31:0] idle_r;
  // Clocks since the last step
  always @(posedge aclk) begin
    if (!aresetn || step_pulse)
      idle_r <= 32'h0;
    else
      idle_r <= idle_r + 32'h1;
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_stst_clear: assert property (step_pulse |=> !standstill)
    else $error("standstill held after step");
  a_stst_early: assert property ($rose(standstill) |-> idle_r >= STST_CLKS - 3)
    else $error("standstill too early");
  a_stst_late: assert property (idle_r == STST_CLKS + 2 |-> standstill)
    else $error("standstill too late");
  a_hold_no_rise: assert property (standstill && $past(standstill) |-> current_scale <= $past(current_scale))
    else $error("scale rose at standstill");
  a_load_excl: assert property (high_speed_active |-> !load_adapt_active)
    else $error("load mode during high speed");
  a_wr_resp: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write response late");
  a_b_done: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid && s_axi_awready)
    else $error("write response not closed");
  a_rd_resp: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read data late");
  a_r_done: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready)
    else $error("read not closed");
endmodule

bind mcsv_top mcsv_checker #(.STST_CLKS(STST_CLKS)) u_chk (.*);

// ===== tb/test_mcsv_top.sv
// Self-checking bench for the current scale and velocity mode block
`timescale 1ns/1ps
module test_mcsv_top;
  localparam integer TICK = 16;
  localparam integer STST = 512;
  reg               aclk, aresetn, step_pulse, s_axi_awvalid, s_axi_wvalid;
  reg               s_axi_bready, s_axi_arvalid, s_axi_rready;
  reg  [7:0]        s_axi_awaddr, s_axi_araddr;
  reg  [31:0]       s_axi_wdata;
  reg  [3:0]        s_axi_wstrb;
  reg  signed [8:0] sine_a_in, sine_b_in;
  reg  [4:0]        load_adapt_scale_req;
  wire              s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0]        s_axi_bresp, s_axi_rresp;
  wire [31:0]       s_axi_rdata;
  wire signed [8:0] coil_a_out, coil_b_out;
  wire [4:0]        current_scale;
  wire              standstill, quiet_mode_active, high_speed_active, load_adapt_active;
  integer           bad_count, checks, n;

  mcsv_top #(.TICK_CLKS(TICK), .STST_CLKS(STST)) dut (.*);

  task final_report;
    begin
      $display("checks=%0d bad_count=%0d", checks, bad_count);
      if (bad_count == 0 && checks > 0)
        $display("All checks passed");
      else
        $display("Checks failed");
      $finish;
    end
  endtask

  task cmp(input [31:0] got, input [31:0] exp);
    begin
      checks = checks + 1;
      if (got !== exp) begin
        bad_count = bad_count + 1;
        $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask

  task cmp_rng(input [31:0] got, input [31:0] lo, input [31:0] hi);
    begin
      checks = checks + 1;
      if (!(got >= lo && got <= hi)) begin
        bad_count = bad_count + 1;
        $display("[ERR] t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
      end
    end
  endtask

  task limit_chk;
    begin
      if (n >= 1000) begin
        bad_count = bad_count + 1;
        final_report;
      end
    end
  endtask

  task wr(input [7:0] a, input [31:0] d, input [1:0] er);
    begin
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      n = 0;
      do begin
        @(posedge aclk);
        n = n + 1;
        if (s_axi_awready) s_axi_awvalid <= 1'h0;
        if (s_axi_wready) s_axi_wvalid <= 1'h0;
      end while (s_axi_bvalid !== 1'h1 && n < 1000);
      limit_chk;
      s_axi_bready <= 1'h0;
      cmp(s_axi_bresp, er);
    end
  endtask

  task rdc(input [7:0] a, input [31:0] ed, input [1:0] er);
    begin
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      n = 0;
      do begin
        @(posedge aclk);
        n = n + 1;
        if (s_axi_arready) s_axi_arvalid <= 1'h0;
      end while (s_axi_rvalid !== 1'h1 && n < 1000);
      limit_chk;
      s_axi_rready <= 1'h0;
      cmp(s_axi_rdata, ed);
      cmp(s_axi_rresp, er);
    end
  endtask

  task step(input integer gap);
    begin
      repeat (gap - 1) @(posedge aclk);
      step_pulse <= 1'h1;
      @(posedge aclk);
      step_pulse <= 1'h0;
    end
  endtask

  task wait_stst;
    begin
      n = 0;
      while (standstill !== 1'h1 && n < 1000) begin
        @(posedge aclk);
        n = n + 1;
      end
      limit_chk;
    end
  endtask

  task cnt_cs(input [4:0] v);
    begin
      n = 0;
      while (current_scale === v && n < 1000) begin
        @(posedge aclk);
        n = n + 1;
      end
      limit_chk;
    end
  endtask

  task reset_scen;
    begin
      rdc(8'h1C, 32'h00001F03, 2'h0);
      rdc(8'h00, 32'h0001101F, 2'h0);
      rdc(8'h04, 32'h0000000A, 2'h0);
      rdc(8'h08, 32'h00000000, 2'h0);
      rdc(8'h10, 32'h00000000, 2'h0);
      rdc(8'h18, 32'h00000000, 2'h0);
      rdc(8'h40, 32'h00000000, 2'h2);
      rdc(8'h02, 32'h00000000, 2'h2);
      wr(8'h20, 32'h00000005, 2'h2);
      wr(8'h1C, 32'h00000000, 2'h2);
    end
  endtask

  task scale_scen;
    begin
      sine_a_in <= 9'h0F8;
      sine_b_in <= 9'h1A0;
      wr(8'h00, 32'h00011017, 2'h0);
      wr(8'h08, 32'h00000080, 2'h0);
      step(2);
      repeat (3) @(posedge aclk);
      cmp(current_scale, 32'h17);
      cmp({1'h0, coil_a_out}, 32'h5D);
      cmp({1'h0, coil_b_out}, 32'h1DC);
      wr(8'h08, 32'h00000000, 2'h0);
      repeat (2) @(posedge aclk);
      cmp({1'h0, coil_a_out}, 32'hBA);
      cmp({1'h0, coil_b_out}, 32'h1B8);
      wr(8'h14, 32'h000003E8, 2'h0);
      load_adapt_scale_req <= 5'h0A;
      step(100);
      step(100);
      step(100);
      repeat (4) @(posedge aclk);
      cmp(load_adapt_active, 32'h1);
      cmp(quiet_mode_active, 32'h1);
      cmp(current_scale, 32'h0A);
    end
  endtask

  task hyst_case(input integer gap, input [31:0] exp);
    begin
      step(gap);
      step(gap);
      step(gap);
      cmp(high_speed_active, exp);
      cmp(load_adapt_active, exp ^ 32'h1);
      cmp(quiet_mode_active, 32'h0);
    end
  endtask

  task hyst_scen;
    begin
      wr(8'h0C, 32'h000007D0, 2'h0);
      wr(8'h10, 32'h00000069, 2'h0);
      wr(8'h18, 32'h00000000, 2'h0);
      hyst_case(100, 32'h0);
      wr(8'h18, 32'h00000001, 2'h0);
      hyst_case(100, 32'h1);
      hyst_case(104, 32'h1);
      hyst_case(106, 32'h0);
      wr(8'h18, 32'h00000021, 2'h0);
      hyst_case(400, 32'h1);
      rdc(8'h20, 32'h00000064, 2'h0);
    end
  endtask

  task ramp_scen;
    begin
      load_adapt_scale_req <= 5'h1F;
      wr(8'h18, 32'h00000000, 2'h0);
      wr(8'h00, 32'h00021114, 2'h0);
      wr(8'h04, 32'h00000003, 2'h0);
      step(2);
      wait_stst;
      cmp_rng(n, STST - 3, STST + 3);
      cnt_cs(5'h14);
      cmp_rng(n, 5 * TICK - 2, 5 * TICK + 4);
      cmp(current_scale, 32'h13);
      cnt_cs(5'h13);
      cmp_rng(n, 2 * TICK - 1, 2 * TICK + 1);
      repeat (5 * TICK) @(posedge aclk);
      cmp(current_scale, 32'h11);
      rdc(8'h20, 32'h000FFFFF, 2'h0);
      wr(8'h00, 32'h00000C14, 2'h0);
      step(2);
      wait_stst;
      cnt_cs(5'h14);
      cmp(current_scale, 32'h0C);
    end
  endtask

  initial begin
    aclk = 1'h0;
    forever #10 aclk = ~aclk;
  end

  initial begin
    aresetn = 1'h0;
    step_pulse = 1'h0;
    s_axi_awvalid = 1'h0;
    s_axi_wvalid = 1'h0;
    s_axi_bready = 1'h0;
    s_axi_arvalid = 1'h0;
    s_axi_rready = 1'h0;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hF;
    sine_a_in = 9'h000;
    sine_b_in = 9'h000;
    load_adapt_scale_req = 5'h1F;
    bad_count = 0;
    checks = 0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'h1;
    reset_scen;
    scale_scen;
    hyst_scen;
    ramp_scen;
    final_report;
  end
endmodule
